// ### logic/frl_pkg.sv
// Package with the constants, register map and state encodings of the frame reset and lock status block.
package frl_pkg;

  // Core clock rate.
  localparam int unsigned CLK_HZ         = 20_000_000;

  // Frame reset train rates as exact fractions: 3000/1001 Hz, 25/4 Hz and 3/1 Hz.
  localparam int unsigned FR1_NUM        = 3000;
  localparam int unsigned FR1_DEN        = 1001;
  localparam int unsigned FR2_NUM        = 25;
  localparam int unsigned FR2_DEN        = 4;
  localparam int unsigned FR3_NUM        = 3;
  localparam int unsigned FR3_DEN        = 1;

  // Phase accumulator steps and default moduli; rate = CLK_HZ * step / modulus.
  localparam logic [24:0] FR1_STEP       = 25'h0000003;
  localparam logic [24:0] FR2_STEP       = 25'h0000001;
  localparam logic [24:0] FR3_STEP       = 25'h0000003;
  localparam int unsigned FR1_MOD_DEF    = CLK_HZ / 1000 * FR1_DEN;                     // 20020000
  localparam int unsigned FR2_MOD_DEF    = CLK_HZ * FR2_DEN / FR2_NUM;                  // 3200000
  localparam int unsigned FR3_MOD_DEF    = CLK_HZ * 3 / FR3_NUM * FR3_DEN;             // 20000000
  localparam logic [9:0]  EPOCH_SEC_LAST = 10'h3E8;                                     // 1001 s common period

  // Timing of position acquisition and indicator flash.
  localparam int unsigned ACQ_POS_S      = 60;
  localparam int unsigned ACQ_POS_CYC    = ACQ_POS_S * CLK_HZ;
  localparam int unsigned FLASH_HALF_MS  = 500;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);

  // Lock quality score values and quality thresholds.
  localparam logic [3:0]  SCORE_LOCK_MIN = 4'h6;
  localparam logic [7:0]  QUAL_TH7       = 8'h10;                                       // 16
  localparam logic [7:0]  QUAL_TH8       = 8'h1A;                                       // 26
  localparam logic [7:0]  QUAL_TH9       = 8'h2A;                                       // 42
  localparam logic [7:0]  QUAL_TH10      = 8'h44;                                       // 68
  localparam logic [7:0]  QUAL_TH11      = 8'h6E;                                       // 110

  // Register byte offsets.
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_THRESH     = 8'h04;
  localparam logic [7:0]  OFS_SCORE      = 8'h08;
  localparam logic [7:0]  OFS_EPOCH      = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;

  // Control fields and reset values.
  localparam int unsigned CTRL_EXT_BIT   = 0;
  localparam int unsigned CTRL_SAT_BIT   = 1;
  localparam int unsigned CTRL_REACQ_BIT = 2;
  localparam logic [1:0]  CTRL_RST       = 2'h0;
  localparam logic [3:0]  THRESH_RST     = 4'h6;

  // Interrupt status bits.
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_SCORE_CHG  = 0;
  localparam int unsigned IRQ_WARN       = 1;
  localparam int unsigned IRQ_LOCK_LOST  = 2;
  localparam int unsigned IRQ_POS_STORE  = 3;

  // Lock tracking states.
  typedef enum logic [6:0] {
    ST_NOSIG  = 7'h01,
    ST_LOWSIG = 7'h02,
    ST_ACQSAT = 7'h04,
    ST_BADPOS = 7'h08,
    ST_ACQPOS = 7'h10,
    ST_ADJPH  = 7'h20,
    ST_LOCKED = 7'h40
  } frl_state_t;

endpackage

// ### logic/frl_top.sv
// Frame reset pulse trains, satellite lock quality tracking, indicator drive and AHB-Lite registers.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.

// How it works
// - Frame reset train one at 2.997 Hz.
// - Frame reset train two at 6.250 Hz.
// - Frame reset train three at 3.000 Hz.
// - With satellite timing, align trains at epoch.
// - Internal mode keeps the reference indicator off.
// - External: steady at score six up, else flash.
// - No signal present reports score zero.
// - Weak unusable signal reports score one.
// - Choosing satellites reports score two.
// - Position mismatch reports three, then moves four.
// - Score four averages fixes, stores, also manually.
// - Aligning time base reports score five.
// - Scores six up only within 150 ns.
// - Locked score chosen by signal quality thresholds.
// - Warning when score falls below software threshold.
module frl_top
  import frl_pkg::*;
#(
  parameter int unsigned FR1_MOD   = frl_pkg::FR1_MOD_DEF,    // Train one accumulator modulus.
  parameter int unsigned FR2_MOD   = frl_pkg::FR2_MOD_DEF,    // Train two accumulator modulus.
  parameter int unsigned FR3_MOD   = frl_pkg::FR3_MOD_DEF,    // Train three accumulator modulus.
  parameter int unsigned ACQ_CYC   = frl_pkg::ACQ_POS_CYC,    // Position acquisition length in cycles.
  parameter int unsigned FLASH_CYC = frl_pkg::FLASH_HALF_CYC  // Half flash period in cycles.
) (
  input  wire logic        core_clk_i,       // System clock, 20 MHz.
  input  wire logic        nrst_i,           // Synchronous reset, active low.
  input  wire logic        hsel_i,           // AHB slave select.
  input  wire logic [31:0] haddr_i,          // AHB address.
  input  wire logic [1:0]  htrans_i,         // AHB transfer type.
  input  wire logic        hwrite_i,         // AHB write flag.
  input  wire logic [2:0]  hsize_i,          // AHB transfer size.
  input  wire logic [31:0] hwdata_i,         // AHB write data.
  input  wire logic        hready_i,         // AHB bus ready.
  output logic      [31:0] hrdata_o,         // AHB read data.
  output logic             hreadyout_o,      // AHB slave ready.
  output logic             hresp_o,          // AHB response, always OKAY.
  input  wire logic        rx_present_i,     // Receiver sees some signal.
  input  wire logic        rx_usable_i,      // Receiver can extract timing.
  input  wire logic        rx_selected_i,    // Receiver has chosen its satellites.
  input  wire logic        rx_pos_diff_i,    // Stored position differs from fix.
  input  wire logic        rx_fix_i,         // Toggles on each new position fix.
  input  wire logic        rx_phase_ok_i,    // Frame phase within 150 ns of satellite.
  input  wire logic        rx_pps_i,         // Satellite pulse per second.
  input  wire logic [7:0]  rx_quality_i,     // Signal quality figure.
  output logic      [2:0]  frame_rst_o,      // Frame reset pulses, one per train.
  output logic             ref_led_o,        // External reference indicator.
  output logic             warn_o,           // Signal warning level.
  output logic             pos_store_o,      // Pulse: write averaged position.
  output logic             irq_o             // Level interrupt.
);
  import frl_pkg::*;

  // Two-flop synchronisers for all receiver pins.
  // Quality is not gray coded; hold it three cycles.
  logic [14:0] rx_meta;
  logic [14:0] rx_sync;
  logic        pps_d;
  logic        fix_d;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rx_meta <= 15'h0000;
      rx_sync <= 15'h0000;
      pps_d   <= 1'b0;
      fix_d   <= 1'b0;
    end else begin
      rx_meta <= {rx_quality_i, rx_pps_i, rx_phase_ok_i, rx_fix_i, rx_pos_diff_i,
                  rx_selected_i, rx_usable_i, rx_present_i};
      rx_sync <= rx_meta;
      pps_d   <= rx_sync[6];
      fix_d   <= rx_sync[4];
    end
  end

  // Synchronised levels and edge events.
  logic       s_present, s_usable, s_selected, s_pos_diff, s_phase_ok, pps_edge, fix_evt;
  logic [7:0] s_quality;
  assign s_present  = rx_sync[0];
  assign s_usable   = rx_sync[1];
  assign s_selected = rx_sync[2];
  assign s_pos_diff = rx_sync[3];
  assign s_phase_ok = rx_sync[5];
  assign s_quality  = rx_sync[14:7];
  assign pps_edge   = rx_sync[6] & ~pps_d;
  assign fix_evt    = rx_sync[4] ^ fix_d;

  // Registers; software writes all but score and state, which it only reads.
  logic [1:0]        ctrl;
  logic [3:0]        thresh;
  logic [9:0]        epoch_sec;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [3:0]        score;
  frl_state_t        state;

  // AHB-Lite slave: writes take effect at the data phase edge, reads insert one wait state
  // so that hrdata comes from a flop and already sees a write made just before.
  logic       ap_wr, ap_rd, rd_wait;
  logic [7:0] ap_addr;
  logic       take;
  logic       wr_en;
  assign take        = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = ~(ap_rd & ~rd_wait);
  assign hresp_o     = 1'b0;
  assign wr_en       = ap_wr;

  // Address phase capture, frozen during a read wait.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ap_wr   <= 1'b0;
      ap_rd   <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready_i) begin
      ap_wr   <= take & hwrite_i;
      ap_rd   <= take & ~hwrite_i;
      ap_addr <= haddr_i[7:0];
    end
  end

  // Read data mux, loaded during the wait cycle; unmapped offsets read zero.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rd_wait  <= 1'b0;
      hrdata_o <= 32'h00000000;
    end else if (ap_rd && !rd_wait) begin
      rd_wait <= 1'b1;
      case (ap_addr)
        OFS_CTRL:     hrdata_o <= {30'h00000000, ctrl};
        OFS_THRESH:   hrdata_o <= {28'h0000000, thresh};
        OFS_SCORE:    hrdata_o <= {21'h000000, state, score};
        OFS_EPOCH:    hrdata_o <= {22'h000000, epoch_sec};
        OFS_IRQ_STAT: hrdata_o <= {28'h0000000, irq_stat};
        OFS_IRQ_MASK: hrdata_o <= {28'h0000000, irq_mask};
        default:      hrdata_o <= 32'h00000000;
      endcase
    end else begin
      rd_wait <= 1'b0;
    end
  end

  // Control, threshold and mask registers.
  logic reacq_req;
  assign reacq_req = wr_en && ap_addr == OFS_CTRL && hwdata_i[CTRL_REACQ_BIT];
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ctrl     <= CTRL_RST;
      thresh   <= THRESH_RST;
      irq_mask <= '0;
    end else if (wr_en) begin
      if (ap_addr == OFS_CTRL)     ctrl     <= hwdata_i[1:0];
      if (ap_addr == OFS_THRESH)   thresh   <= hwdata_i[3:0];
      if (ap_addr == OFS_IRQ_MASK) irq_mask <= hwdata_i[IRQ_W-1:0];
    end
  end

  // Epoch second counter modulo 1001; software loads it, the pulse per second advances it.
  logic epoch_align;
  assign epoch_align = ctrl[CTRL_SAT_BIT] & pps_edge & (epoch_sec == EPOCH_SEC_LAST);
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      epoch_sec <= 10'h000;
    end else if (wr_en && ap_addr == OFS_EPOCH) begin
      epoch_sec <= hwdata_i[9:0];
    end else if (pps_edge) begin
      epoch_sec <= (epoch_sec == EPOCH_SEC_LAST) ? 10'h000 : epoch_sec + 10'h001;
    end
  end

  // Three rational phase accumulators; trains one and three meet every 1001 s, train two every 4004 s, so the epoch restart
  // keeps them aligned with each other and with satellite time.
  localparam int unsigned FR_MOD [3]  = '{FR1_MOD, FR2_MOD, FR3_MOD};
  localparam logic [24:0] FR_STEP [3] = '{FR1_STEP, FR2_STEP, FR3_STEP};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_train
      logic [24:0] acc;
      logic [25:0] sum;
      assign sum = {1'b0, acc} + {1'b0, FR_STEP[g]};
      // Epoch restart outranks the wrap.
      always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
          acc            <= 25'h0000000;
          frame_rst_o[g] <= 1'b0;
        end else if (epoch_align) begin
          acc            <= 25'h0000000;
          frame_rst_o[g] <= 1'b1;
        end else if (sum >= 26'(FR_MOD[g])) begin
          acc            <= 25'(sum - 26'(FR_MOD[g]));
          frame_rst_o[g] <= 1'b1;
        end else begin
          acc            <= sum[24:0];
          frame_rst_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Lock tracking state machine.
  logic [31:0] acq_cnt;
  logic        acq_done;
  frl_state_t  next_state;
  assign acq_done = (acq_cnt >= ACQ_CYC - 1);
  // Signal loss and manual requests win.
  always_comb begin
    next_state = state;
    if (!s_present) begin
      next_state = ST_NOSIG;
    end else if (!s_usable) begin
      next_state = ST_LOWSIG;
    end else if (reacq_req) begin
      next_state = ST_ACQPOS;
    end else begin
      case (state)
        ST_NOSIG, ST_LOWSIG: next_state = ST_ACQSAT;
        ST_ACQSAT: begin
          if (s_selected) next_state = s_pos_diff ? ST_BADPOS : ST_ADJPH;
        end
        ST_BADPOS: next_state = ST_ACQPOS;
        ST_ACQPOS: begin
          if (acq_done) next_state = ST_ADJPH;
        end
        ST_ADJPH: begin
          if (s_phase_ok) next_state = ST_LOCKED;
        end
        ST_LOCKED: begin
          if (!s_phase_ok) next_state = ST_ADJPH;
        end
        default: next_state = ST_NOSIG;
      endcase
    end
  end

  // State register.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) state <= ST_NOSIG;
    else         state <= next_state;
  end

  // Acquisition timer and fix accumulation; the store pulse fires once when averaging ends.
  logic [15:0] fix_cnt;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      acq_cnt     <= 32'h00000000;
      fix_cnt     <= 16'h0000;
      pos_store_o <= 1'b0;
    end else begin
      pos_store_o <= 1'b0;
      // Leaving acquisition clears the counters.
      if (state != ST_ACQPOS || next_state != ST_ACQPOS) begin
        acq_cnt <= 32'h00000000;
        fix_cnt <= 16'h0000;
        if (state == ST_ACQPOS && next_state == ST_ADJPH) begin
          pos_store_o <= (fix_cnt != 16'h0000);
        end
      end else begin
        acq_cnt <= acq_cnt + 32'h00000001;
        if (fix_evt) fix_cnt <= fix_cnt + 16'h0001;
      end
    end
  end

  // Score from state; locked score chosen by quality thresholds.
  logic [3:0] next_score;
  always_comb begin
    case (state)
      ST_NOSIG:  next_score = 4'h0;
      ST_LOWSIG: next_score = 4'h1;
      ST_ACQSAT: next_score = 4'h2;
      ST_BADPOS: next_score = 4'h3;
      ST_ACQPOS: next_score = 4'h4;
      ST_ADJPH:  next_score = 4'h5;
      // A figure equal to a threshold stays lower.
      ST_LOCKED: begin
        if      (s_quality > QUAL_TH11) next_score = 4'hB;
        else if (s_quality > QUAL_TH10) next_score = 4'hA;
        else if (s_quality > QUAL_TH9)  next_score = 4'h9;
        else if (s_quality > QUAL_TH8)  next_score = 4'h8;
        else if (s_quality > QUAL_TH7)  next_score = 4'h7;
        else                            next_score = 4'h6;
      end
      default:   next_score = 4'h0;
    endcase
  end

  // Score register, read by the indicator.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) score <= 4'h0;
    else         score <= next_score;
  end

  // Warning level; registered from the next score, so it changes in the same cycle as the score.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) warn_o <= 1'b0;
    else         warn_o <= (next_score < thresh);
  end

  // Flash enable divider: one pulse every half period gives a 50 percent duty.
  // Free running: a flash may start mid-period.
  logic [31:0] flash_cnt;
  logic        flash_ph;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      flash_cnt <= 32'h00000000;
      flash_ph  <= 1'b0;
    end else if (flash_cnt >= FLASH_CYC - 1) begin
      flash_cnt <= 32'h00000000;
      flash_ph  <= ~flash_ph;
    end else begin
      flash_cnt <= flash_cnt + 32'h00000001;
    end
  end

  // Indicator drive.
  // The indicator lags the score by one cycle.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i)                      ref_led_o <= 1'b0;
    else if (!ctrl[CTRL_EXT_BIT])     ref_led_o <= 1'b0;
    else if (score >= SCORE_LOCK_MIN) ref_led_o <= 1'b1;
    else                              ref_led_o <= flash_ph;
  end

  // Sticky interrupt status; a hardware event wins over a write-one clear in the same cycle.
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_evt[IRQ_SCORE_CHG] = (next_score != score);
  assign irq_evt[IRQ_WARN]      = (next_score < thresh) & ~warn_o;
  assign irq_evt[IRQ_LOCK_LOST] = (state == ST_LOCKED) & (next_state != ST_LOCKED);
  assign irq_evt[IRQ_POS_STORE] = pos_store_o;

  // Writing one clears; zero leaves a bit.
  assign irq_clr = (wr_en && ap_addr == OFS_IRQ_STAT) ? hwdata_i[IRQ_W-1:0] : '0;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
      irq_o    <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_mask);
    end
  end

  // Checks of the documented behaviour.
  // Reset disables every check.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_led_internal_off: assert property (!ctrl[CTRL_EXT_BIT] |=> !ref_led_o)
    else $error("indicator lit in internal mode");
  a_led_locked_on: assert property (ctrl[CTRL_EXT_BIT] && score >= SCORE_LOCK_MIN |=> ref_led_o)
    else $error("indicator not steady while locked");
  a_led_flash_phase: assert property (ctrl[CTRL_EXT_BIT] && score < SCORE_LOCK_MIN |=> ref_led_o == $past(flash_ph))
    else $error("indicator does not follow flash phase");
  a_nosig_score_zero: assert property (!s_present |=> ##1 score == 4'h0)
    else $error("score not zero without signal");
  a_lowsig_score_one: assert property (s_present && !s_usable |=> ##1 score == 4'h1)
    else $error("score not one with weak signal");
  a_badpos_to_acq: assert property (state == ST_BADPOS && s_present && s_usable |=> state == ST_ACQPOS)
    else $error("bad position did not move to acquisition");
  a_lock_needs_phase: assert property (score >= SCORE_LOCK_MIN |-> $past(state) == ST_LOCKED)
    else $error("locked score without phase lock");
  a_top_quality_score: assert property (state == ST_LOCKED && s_quality > QUAL_TH11 |=> score == 4'hB)
    else $error("wrong score for top quality");
  a_warn_below_thresh: assert property ($past(nrst_i) && score < thresh && $stable(thresh) |-> warn_o)
    else $error("warning missing below threshold");
  a_epoch_realign: assert property (epoch_align |=> frame_rst_o == 3'h7)
    else $error("trains not restarted together at epoch");

endmodule

// ### bench/frl_rx_model.sv
// Behavioural model of the satellite timing receiver that feeds the lock tracker.
module frl_rx_model (
  input  wire logic       core_clk_i,  // Bench clock.
  input  wire logic [1:0] stage_i,     // 0 none, 1 weak, 2 usable, 3 satellites chosen.
  input  wire logic       pos_diff_i,  // Fix disagrees with the stored position.
  input  wire logic       phase_ok_i,  // Frame phase inside the lock window.
  input  wire logic [7:0] qual_i,      // Quality figure to report.
  input  wire logic       pps_go_i,    // Strobe that emits one second pulse.
  output logic            present_o,   // Some signal seen.
  output logic            usable_o,    // Timing can be extracted.
  output logic            selected_o,  // Satellites chosen.
  output logic            pos_diff_o,  // Position mismatch.
  output logic            fix_o,       // Toggles once per fix.
  output logic            phase_ok_o,  // Phase inside window.
  output logic            pps_o,       // Pulse per second.
  output logic      [7:0] quality_o    // Quality figure.
);
  logic [2:0] fix_cnt;
  logic [2:0] pps_cnt;

  // Known levels from time zero, since the tracker only resets its own flops.
  initial begin
    {present_o, usable_o, selected_o, pos_diff_o, fix_o, phase_ok_o} = 6'h00;
    quality_o = 8'h00;
    fix_cnt = 3'h0;
    pps_cnt = 3'h0;
  end

  // Levels are registered, as the receiver refreshes them on its own tick.
  always @(posedge core_clk_i) begin
    present_o  <= stage_i != 2'h0;
    usable_o   <= stage_i[1];
    selected_o <= stage_i == 2'h3;
    pos_diff_o <= pos_diff_i;
    phase_ok_o <= phase_ok_i;
    quality_o  <= qual_i;
  end

  // A fix every eight cycles while tracking; the second pulse is held five cycles to meet the minimum width.
  always @(posedge core_clk_i) begin
    fix_cnt <= fix_cnt + 3'h1;
    if (stage_i == 2'h3 && fix_cnt == 3'h7) begin
      fix_o <= ~fix_o;
    end
    if (pps_go_i) begin
      pps_cnt <= 3'h5;
    end else if (pps_cnt != 3'h0) begin
      pps_cnt <= pps_cnt - 3'h1;
    end
  end
  assign pps_o = pps_cnt != 3'h0;
endmodule

// ### bench/frl_top_tb_top.sv
// Self-checking bench: bus master, receiver model, lock ladder, indicator, interrupt and frame train checks.
module frl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import frl_pkg::*;
  localparam int unsigned M1 = 20020;
  localparam int unsigned M2 = 3200;
  localparam int unsigned M3 = 20000;
  localparam int unsigned ACQ = 50;
  localparam int unsigned FL = 8;
  logic        core_clk, nrst, hsel, hwrite, hrdy, resp, pos_diff, phase_ok, pps_go;
  logic        led, warn, pstore, irq, p_o, u_o, s_o, d_o, f_o, k_o, pps, rd_ph, fr_on;
  logic [1:0]  htrans, stage;
  logic [2:0]  frst;
  logic [7:0]  qual, q_o;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [31:0] exp_q[$];
  int          fail_count, tests_run, stores, cyc, nper;
  int          last[3];

  // Free-running 20 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  frl_top #(.FR1_MOD(M1), .FR2_MOD(M2), .FR3_MOD(M3), .ACQ_CYC(ACQ), .FLASH_CYC(FL)) DUT (
    .core_clk_i(core_clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(resp), .rx_present_i(p_o), .rx_usable_i(u_o), .rx_selected_i(s_o),
    .rx_pos_diff_i(d_o), .rx_fix_i(f_o), .rx_phase_ok_i(k_o), .rx_pps_i(pps), .rx_quality_i(q_o),
    .frame_rst_o(frst), .ref_led_o(led), .warn_o(warn), .pos_store_o(pstore), .irq_o(irq));

  frl_rx_model RX (
    .core_clk_i(core_clk), .stage_i(stage), .pos_diff_i(pos_diff), .phase_ok_i(phase_ok), .qual_i(qual),
    .pps_go_i(pps_go), .present_o(p_o), .usable_o(u_o), .selected_o(s_o), .pos_diff_o(d_o), .fix_o(f_o),
    .phase_ok_o(k_o), .pps_o(pps), .quality_o(q_o));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // The ready level is read at the falling edge, so the next rising edge is the one that samples it.
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge core_clk);
    while (hrdy !== 1'b1 && n < 16) begin
      n++;
      @(negedge core_clk);
    end
    if (n >= 16) begin
      fail_count++;
      $display("CHECK FAILED t=%0t bus hang", $time);
      finish_test();
    end
    @(posedge core_clk);
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph  = !w;
    wait_rdy();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  // Score tracking lags the pins by about five cycles; twelve leaves margin.
  task automatic settle();
    repeat (12) @(posedge core_clk);
  endtask

  task automatic led_win(input logic e);
    repeat (16) begin
      @(negedge core_clk);
      chk(32'(led), 32'(e), "indicator");
    end
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] exp_sc(input int s);
    logic [6:0] st;
    st = 7'h01 << ((s > 6) ? 6 : s);
    return {21'h0, st, 4'(s)};
  endfunction

  function automatic int lock_sc(input logic [7:0] q);
    return 6 + int'(q > 8'h10) + int'(q > 8'h1A) + int'(q > 8'h2A) + int'(q > 8'h44) + int'(q > 8'h6E);
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Result watcher: takes the oldest expected read word when a read data phase completes.
  always @(negedge core_clk) begin
    if (rd_ph && hrdy === 1'b1) begin
      rd_ph = 1'b0;
      chk(hrdata, exp_q.pop_front(), "read data");
    end
  end

  // Output watcher: counts store pulses and measures each frame train interval while fr_on is set.
  always @(negedge core_clk) begin
    cyc++;
    if (pstore === 1'b1) stores++;
    for (int i = 0; i < 3; i++) begin
      if (frst[i] === 1'b1) begin
        if (fr_on && last[i] != 0) begin
          nper++;
          chk(32'(((cyc - last[i]) * 3 + 2) / 3 inside {M1 / 3, M1 / 3 + 1} || i != 0), 1, "train one");
          chk(32'(cyc - last[i] == M2 || i != 1), 1, "train two");
          chk(32'((cyc - last[i]) inside {M3 / 3, M3 / 3 + 1} || i != 2), 1, "train three");
        end
        last[i] = cyc;
      end
    end
  end

  // Hang guard for the whole run.
  initial begin
    repeat (90000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end

  initial begin
    logic [7:0] qs[16];
    int tog;
    logic found;
    {nrst, hsel, hwrite, pos_diff, phase_ok, pps_go, rd_ph, fr_on} = 8'h00;
    {htrans, stage, qual, haddr, hwdata} = '0;
    {fail_count, tests_run, stores, cyc, nper} = '0;
    last = '{0, 0, 0};
    seed = 32'h3F;
    qs = '{8'h10, 8'h11, 8'h1A, 8'h1B, 8'h2A, 8'h2B, 8'h44, 8'h45, 8'h6E, 8'h6F, 0, 0, 0, 0, 0, 0};
    for (int i = 10; i < 16; i++) begin
      seed = xs(seed);
      qs[i] = seed[7:0];
    end
    repeat (2) @(posedge core_clk);
    nrst  <= 1'b1;
    fr_on <= 1'b1;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_THRESH, 32'h6);
    rd(OFS_IRQ_MASK, 32'h0);
    bus(8'h18, 1'b1, 32'hFFFF_FFFF);
    rd(8'h18, 32'h0);
    rd(OFS_SCORE, exp_sc(0));
    bus(OFS_SCORE, 1'b1, 32'h5);
    rd(OFS_SCORE, exp_sc(0));
    chk(32'({resp, warn}), 32'h1, "reset warn");
    $display("test registers done");
    stage <= 2'h1;
    settle();
    rd(OFS_SCORE, exp_sc(1));
    stage <= 2'h2;
    settle();
    rd(OFS_SCORE, exp_sc(2));
    stage    <= 2'h3;
    pos_diff <= 1'b1;
    settle();
    rd(OFS_SCORE, exp_sc(4));
    pos_diff <= 1'b0;
    repeat (ACQ + 12) @(posedge core_clk);
    chk(32'(stores), 1, "position stored");
    rd(OFS_SCORE, exp_sc(5));
    phase_ok <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      qual <= qs[i];
      settle();
      rd(OFS_SCORE, exp_sc(lock_sc(qs[i])));
    end
    $display("test lock ladder done");
    qual <= 8'h32;
    settle();
    led_win(1'b0);
    bus(OFS_CTRL, 1'b1, 32'h1);
    settle();
    led_win(1'b1);
    phase_ok <= 1'b0;
    settle();
    rd(OFS_SCORE, exp_sc(5));
    tog = 0;
    @(negedge core_clk);
    found = led;
    repeat (128) begin
      @(negedge core_clk);
      tog += int'(found !== led);
      found = led;
    end
    chk(32'(tog), 32'(128 / FL), "flash toggles");
    @(posedge core_clk);
    bus(OFS_CTRL, 1'b1, 32'h0);
    settle();
    led_win(1'b0);
    $display("test indicator done");
    phase_ok <= 1'b1;
    bus(OFS_THRESH, 1'b1, 32'h9);
    settle();
    chk(32'(warn), 1'b0, "score equal threshold");
    bus(OFS_IRQ_STAT, 1'b1, 32'hF);
    rd(OFS_IRQ_STAT, 32'h0);
    bus(OFS_IRQ_MASK, 1'b1, 32'h1 << IRQ_WARN);
    bus(OFS_THRESH, 1'b1, 32'hA);
    settle();
    chk(32'({warn, irq}), 32'h3, "warn raises irq");
    rd(OFS_IRQ_STAT, 32'h1 << IRQ_WARN);
    bus(OFS_IRQ_MASK, 1'b1, 32'h0);
    repeat (2) @(negedge core_clk);
    chk(32'(irq), 32'h0, "masked irq");
    bus(OFS_IRQ_MASK, 1'b1, 32'h1 << IRQ_WARN);
    repeat (2) @(negedge core_clk);
    chk(32'(irq), 32'h1, "unmasked irq");
    bus(OFS_IRQ_STAT, 1'b1, 32'h1 << IRQ_WARN);
    repeat (2) @(negedge core_clk);
    chk(32'(irq), 32'h0, "cleared irq");
    $display("test warning done");
    bus(OFS_CTRL, 1'b1, 32'h4);
    settle();
    rd(OFS_SCORE, exp_sc(4));
    repeat (ACQ + 24) @(posedge core_clk);
    chk(32'(stores), 2, "manual store");
    rd(OFS_SCORE, exp_sc(lock_sc(8'h32)));
    $display("test reacquire done");
    repeat (16000) @(posedge core_clk);
    fr_on <= 1'b0;
    chk(32'(nper >= 6), 1, "trains running");
    $display("test frame trains done");
    bus(OFS_CTRL, 1'b1, 32'h3);
    bus(OFS_EPOCH, 1'b1, 32'h3E7);
    pps_go <= 1'b1;
    @(posedge core_clk);
    pps_go <= 1'b0;
    settle();
    rd(OFS_EPOCH, 32'h3E8);
    pps_go <= 1'b1;
    @(posedge core_clk);
    pps_go <= 1'b0;
    found = 1'b0;
    repeat (20) begin
      @(negedge core_clk);
      if (frst === 3'h7) found = 1'b1;
    end
    chk(32'(found), 1, "aligned pulses");
    rd(OFS_EPOCH, 32'h0);
    $display("test epoch done");
    finish_test();
  end
endmodule
